// ===== hw/eeprom_dev.sv
// eeprom device end: two-wire target with 512-byte array, byte write and read
// assumes controller drives the serial clock; link lines sampled through 3 flops
// Function
// (RULE_01) memory address: upper byte first, msb first
// (RULE_02) write data byte shifted msb first
// (RULE_03) sda falling while scl high is start
// (RULE_04) sda rising while scl high is stop
// (RULE_05) read ended by stop returns to standby
// (RULE_06) write stop launches timed program, then standby
// (RULE_07) every unit is eight bits plus acknowledge
// (RULE_08) device drives low ack after received bytes
// (RULE_09) read: release line, ack low sends next
// (RULE_10) no ack then stop ends read
// (RULE_11) no ack, no stop: stay released
// (RULE_12) start followed by address and direction bit
// (RULE_13) address: four-bit type then three-bit select
// (RULE_14) selected when select bits match reference register
// (RULE_15) select code copied from FF09 after reset
// (RULE_16) software keeps stored select code within 0..7
// (RULE_17) direction bit zero writes, one reads
// (RULE_18) wrong type or select: standby, no part
// (RULE_19) byte write: address, upper, lower, data
// (RULE_20) ignore link during internal write cycle
// (RULE_21) sample on rising, drive after falling edge
// (RULE_22) internal write cycle at most ten ms
// (RULE_23) unlock key 5F before rewriting select code; code stores FF09 writes without the key, which gates only sel_ref
// (RULE_24) not selected or busy: ack slot released
module eeprom_dev
	import eeprom_link_pkg::*;
#(
	parameter int unsigned PROG_CYC = WRITE_CYCLE_CYC,
	parameter int unsigned LOAD_WAIT_CYC = LOAD_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// link
	eeprom_link_if.device link,
	// user side: key register write and status
	input wire logic key_we,
	input wire logic [7:0] key_wdata,
	output logic [7:0] key_value,
	output logic busy,
	output logic [2:0] select_code
);
	typedef struct packed {
		dev_state_t st;
		logic [2:0] scl_s, sda_s;
		logic scl_v, sda_v;
		logic [7:0] sh;
		logic [2:0] bcnt;
		logic [1:0] phase;
		logic rw;
		logic ack_ok;
		logic [MEM_AW-1:0] addr;
		logic [15:0] waddr;
		logic [7:0] wdata;
		logic wpend;
		logic [31:0] cnt;
		logic [2:0] sel_ref;
		logic [7:0] key;
		logic sda_oe_n;
		logic busy;
	} dev_reg_t;
	dev_reg_t q, d;
	// array leaves the factory erased to zero, so the stored select code starts at 00
	logic [7:0] mem [MEM_BYTES] = '{default: 8'h00}; // [RULE_16]
	logic mem_we;
	logic scl_rise, scl_fall, start_c, stop_c, scl_now, sda_now;

	always_ff @(posedge clk) begin
		if (ce && mem_we) begin
			mem[q.waddr[MEM_AW-1:0]] <= q.wdata;
		end
	end

	always_comb begin
		d = q;
		mem_we = 1'b0;
		d.scl_s = {q.scl_s[1:0], link.scl};
		d.sda_s = {q.sda_s[1:0], link.sda};
		scl_now = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_v;
		sda_now = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_v;
		d.scl_v = scl_now;
		d.sda_v = sda_now;
		scl_rise = scl_now & ~q.scl_v;
		scl_fall = ~scl_now & q.scl_v;
		start_c = q.scl_v & scl_now & q.sda_v & ~sda_now; // [RULE_03]
		stop_c = q.scl_v & scl_now & ~q.sda_v & sda_now; // [RULE_04]
		if (key_we) begin
			d.key = key_wdata;
		end
		case (q.st)
			D_LOAD: begin
				d.cnt = q.cnt + 32'h1;
				if (q.cnt >= LOAD_WAIT_CYC - 1) begin
					d.sel_ref = mem[SELECT_CODE_LOC[MEM_AW-1:0]][2:0]; // [RULE_15]
					d.busy = 1'b0;
					d.st = D_IDLE;
				end
			end
			D_PROG: begin
				d.sda_oe_n = 1'b1; // [RULE_20] [RULE_24]
				d.cnt = q.cnt + 32'h1;
				if (q.cnt == 32'h0) begin
					mem_we = 1'b1;
					if (q.waddr == SELECT_CODE_LOC && q.key == KEY_UNLOCK) begin
						d.sel_ref = q.wdata[2:0]; // [RULE_23]
						d.key = KEY_RESET;
					end
				end
				if (q.cnt >= PROG_CYC - 1) begin
					d.busy = 1'b0; // [RULE_06] [RULE_22]
					d.st = D_IDLE;
				end
			end
			default: begin
				if (start_c) begin
					d.st = D_ADDR; // [RULE_12]
					d.bcnt = RESET_BITCNT;
					d.phase = 2'h0;
					d.wpend = 1'b0;
					d.sda_oe_n = 1'b1;
				end else if (stop_c) begin
					d.sda_oe_n = 1'b1;
					if (q.wpend) begin
						d.st = D_PROG; // [RULE_06]
						d.cnt = 32'h0;
						d.busy = 1'b1;
					end else begin
						d.st = D_IDLE; // [RULE_05] [RULE_10]
					end
				end else begin
					case (q.st)
						D_ADDR, D_RX: begin
							if (scl_rise) begin
								d.sh = {q.sh[6:0], sda_now}; // [RULE_01] [RULE_02] [RULE_21]
								d.bcnt = q.bcnt - 3'h1;
								if (q.bcnt == 3'h0) begin
									d.st = D_ACK; // [RULE_07]
								end
							end
						end
						D_ACK: begin
							if (scl_fall && q.sda_oe_n) begin
								d.sda_oe_n = 1'b0;
								if (q.phase == 2'h0) begin
									if (q.sh[7:4] != DEV_TYPE_CODE || q.sh[3:1] != q.sel_ref) begin
										d.sda_oe_n = 1'b1; // [RULE_13] [RULE_14] [RULE_18] [RULE_24]
										d.st = D_IDLE;
									end else begin
										d.rw = q.sh[0]; // [RULE_17]
									end
								end else if (q.phase == 2'h1) begin
									d.waddr[15:8] = q.sh; // [RULE_19]
								end else if (q.phase == 2'h2) begin
									d.waddr[7:0] = q.sh;
									d.addr = {q.waddr[MEM_AW-1:8], q.sh};
								end else begin
									d.wdata = q.sh;
									d.wpend = 1'b1;
								end
							end else if (scl_fall) begin
								d.sda_oe_n = 1'b1; // [RULE_08]
								d.bcnt = RESET_BITCNT;
								if (q.phase == 2'h0 && q.rw) begin
									d.st = D_TX;
									d.sh = mem[q.addr];
									d.sda_oe_n = mem[q.addr][7] ? 1'b1 : 1'b0;
								end else if (q.phase == 2'h3) begin
									d.st = D_IDLE;
								end else begin
									d.phase = q.phase + 2'h1;
									d.st = D_RX;
								end
							end
						end
						D_TX: begin
							if (scl_fall) begin
								d.bcnt = q.bcnt - 3'h1;
								if (q.bcnt == 3'h0) begin
									d.sda_oe_n = 1'b1; // [RULE_09]
									d.addr = q.addr + 9'h1;
									d.st = D_RACK;
								end else begin
									d.sh = {q.sh[6:0], 1'b0};
									d.sda_oe_n = q.sh[6] ? 1'b1 : 1'b0; // [RULE_21]
								end
							end
						end
						D_RACK: begin
							if (scl_rise) begin
								d.ack_ok = ~sda_now;
							end
							if (scl_fall) begin
								if (q.ack_ok) begin
									d.st = D_TX; // [RULE_09]
									d.bcnt = RESET_BITCNT;
									d.sh = mem[q.addr];
									d.sda_oe_n = mem[q.addr][7] ? 1'b1 : 1'b0;
								end else begin
									d.st = D_IDLE; // [RULE_11]
									d.sda_oe_n = 1'b1;
								end
							end
						end
						default: d.sda_oe_n = 1'b1;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{st: D_LOAD, scl_s: 3'h7, sda_s: 3'h7, scl_v: 1'b1, sda_v: 1'b1,
				sh: 8'h00, bcnt: 3'h7, phase: 2'h0, rw: 1'b0, ack_ok: 1'b0,
				addr: '0, waddr: 16'h0000, wdata: 8'h00, wpend: 1'b0, cnt: 32'h0,
				sel_ref: SELECT_CODE_INIT[2:0], key: KEY_RESET, sda_oe_n: 1'b1,
				busy: 1'b1};
		end else if (ce) begin
			q <= d;
		end
	end

	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe_n = q.sda_oe_n;
	assign key_value = q.key;
	assign busy = q.busy;
	assign select_code = q.sel_ref;
endmodule

// ===== hw/eeprom_link_pkg.sv
// package: constants and types shared by the two ends of the two-wire eeprom link
// assumes a 50 MHz system clock on both ends
package eeprom_link_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	// device-type code sits in the upper four address bits; value arbitrary
	localparam logic [3:0] DEV_TYPE_CODE = 4'h6;
	localparam logic [15:0] SELECT_CODE_LOC = 16'hFF09;
	localparam logic [7:0] SELECT_CODE_INIT = 8'h00;
	localparam logic [7:0] KEY_UNLOCK = 8'h5F;
	localparam logic [7:0] KEY_RESET = 8'hFF;
	localparam int unsigned MEM_BYTES = 512;
	localparam int unsigned MEM_AW = 9;
	localparam int unsigned BYTE_BITS = 8;
	// internal write cycle time, ms, and its cycle count (longest time rounds down)
	localparam int unsigned WRITE_CYCLE_MS = 10;
	localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_HZ / 1000);
	// select-code copy after reset, ms
	localparam int unsigned LOAD_MS = 10;
	localparam int unsigned LOAD_CYC = LOAD_MS * (CLK_HZ / 1000);
	// controller: quarter period of the generated serial clock (one phase), in clk cycles
	localparam int unsigned HALF_SCL_CYC = 64;
	localparam logic [2:0] RESET_BITCNT = 3'h7;
	typedef enum logic [7:0] {
		D_IDLE = 8'h01, D_ADDR = 8'h02, D_ACK = 8'h04, D_RX = 8'h08,
		D_TX = 8'h10, D_RACK = 8'h20, D_PROG = 8'h40, D_LOAD = 8'h80
	} dev_state_t;
	typedef enum logic [7:0] {
		C_IDLE = 8'h01, C_START = 8'h02, C_BIT = 8'h04, C_ACK = 8'h08,
		C_RBIT = 8'h10, C_MACK = 8'h20, C_STOP = 8'h40, C_DONE = 8'h80
	} ctl_state_t;
endpackage

// ===== hw/eeprom_link_if.sv
// interface: the two-wire link between controller and eeprom device
// assumes an external pull-up: a line is low when any end enables its driver
interface eeprom_link_if;
	logic scl_o, scl_oe_n;
	logic sda_ctl_o, sda_ctl_oe_n;
	logic sda_dev_o, sda_dev_oe_n;
	logic scl, sda;
	// open drain: enable low means driving low
	assign scl = ~(~scl_oe_n & ~scl_o);
	assign sda = ~((~sda_ctl_oe_n & ~sda_ctl_o) | (~sda_dev_oe_n & ~sda_dev_o));
	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
	modport controller (input scl, input sda, output scl_o, output scl_oe_n,
		output sda_ctl_o, output sda_ctl_oe_n);
endinterface

// ===== hw/eeprom_ctl.sv
// controller end: drives the serial clock and runs byte writes and single reads
// assumes the device end on the same link; sda sampled through 3 flops
module eeprom_ctl
	import eeprom_link_pkg::*;
#(
	parameter int unsigned HALF_CYC = HALF_SCL_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// link
	eeprom_link_if.controller link,
	// request
	input wire logic req,
	input wire logic req_rd,
	input wire logic [2:0] req_sel,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_wdata,
	// answer
	output logic done,
	output logic nack,
	output logic [7:0] rdata,
	output logic idle
);
	typedef struct packed {
		ctl_state_t st;
		logic [2:0] sda_s;
		logic sda_v;
		logic [15:0] tick;
		logic [1:0] ph;
		logic [2:0] bcnt;
		logic [2:0] byte_i;
		logic [7:0] sh;
		logic rd, nack, done, scl_oe_n, sda_oe_n;
		logic [15:0] addr;
		logic [7:0] wd, rdata;
		logic [2:0] sel;
	} ctl_reg_t;
	ctl_reg_t q, d;
	logic step, sda_in;

	always_comb begin
		d = q;
		d.sda_s = {q.sda_s[1:0], link.sda};
		// hold the last agreed level while the two sampling flops disagree
		sda_in = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_v;
		d.sda_v = sda_in;
		d.done = 1'b0;
		step = (q.tick == HALF_CYC[15:0] - 16'h1);
		d.tick = (step || q.st == C_IDLE) ? 16'h0 : q.tick + 16'h1;
		if (step) begin
			d.ph = q.ph + 2'h1;
		end
		case (q.st)
			C_IDLE: begin
				d.ph = 2'h0;
				d.scl_oe_n = 1'b1;
				d.sda_oe_n = 1'b1;
				if (req) begin
					d.rd = req_rd;
					d.sel = req_sel;
					d.addr = req_addr;
					d.wd = req_wdata;
					d.nack = 1'b0;
					d.byte_i = 3'h0;
					d.st = C_START;
				end
			end
			C_START: if (step) begin
				if (q.ph == 2'h0) begin
					d.sda_oe_n = 1'b0; // [RULE_03]
				end else if (q.ph == 2'h1) begin
					d.scl_oe_n = 1'b0;
					d.sh = {DEV_TYPE_CODE, q.sel, q.rd}; // [RULE_12] [RULE_13] [RULE_17]
					d.bcnt = RESET_BITCNT;
					d.ph = 2'h0;
					d.st = q.rd ? C_BIT : C_BIT;
				end
			end
			C_BIT, C_RBIT: if (step) begin
				// ph0: set data while low, ph1: raise, ph2: hold high, ph3: drop
				if (q.ph == 2'h0) begin
					d.sda_oe_n = (q.st == C_RBIT) ? 1'b1 : q.sh[7]; // [RULE_01] [RULE_02]
				end else if (q.ph == 2'h1) begin
					d.scl_oe_n = 1'b1;
				end else if (q.ph == 2'h2) begin
					if (q.st == C_RBIT) begin
						d.sh = {q.sh[6:0], sda_in};
					end
				end else begin
					d.scl_oe_n = 1'b0;
					if (q.st == C_BIT) begin
						d.sh = {q.sh[6:0], 1'b0};
					end
					d.bcnt = q.bcnt - 3'h1;
					if (q.bcnt == 3'h0) begin
						d.st = (q.st == C_RBIT) ? C_MACK : C_ACK; // [RULE_07]
					end
				end
			end
			C_ACK: if (step) begin
				if (q.ph == 2'h0) begin
					d.sda_oe_n = 1'b1;
				end else if (q.ph == 2'h1) begin
					d.scl_oe_n = 1'b1;
				end else if (q.ph == 2'h2) begin
					d.nack = q.nack | sda_in; // [RULE_24]
				end else begin
					d.scl_oe_n = 1'b0;
					d.bcnt = RESET_BITCNT;
					d.byte_i = q.byte_i + 3'h1;
					if (q.nack) begin
						d.st = C_STOP;
					end else if (q.rd) begin
						d.st = C_RBIT;
					end else if (q.byte_i == 3'h0) begin
						d.sh = q.addr[15:8]; // [RULE_19]
						d.st = C_BIT;
					end else if (q.byte_i == 3'h1) begin
						d.sh = q.addr[7:0];
						d.st = C_BIT;
					end else if (q.byte_i == 3'h2) begin
						d.sh = q.wd;
						d.st = C_BIT;
					end else begin
						d.st = C_STOP;
					end
				end
			end
			C_MACK: if (step) begin
				// single-byte read: answer with not-acknowledge, then stop
				if (q.ph == 2'h0) begin
					d.rdata = q.sh;
					d.sda_oe_n = 1'b1;
				end else if (q.ph == 2'h1) begin
					d.scl_oe_n = 1'b1;
				end else if (q.ph == 2'h3) begin
					d.scl_oe_n = 1'b0;
					d.st = C_STOP; // [RULE_10]
				end
			end
			C_STOP: if (step) begin
				if (q.ph == 2'h0) begin
					d.sda_oe_n = 1'b0;
				end else if (q.ph == 2'h1) begin
					d.scl_oe_n = 1'b1;
				end else if (q.ph == 2'h2) begin
					d.sda_oe_n = 1'b1; // [RULE_04]
					d.st = C_DONE;
				end
			end
			C_DONE: begin
				d.done = 1'b1;
				d.st = C_IDLE;
			end
			default: d.st = C_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{st: C_IDLE, sda_s: 3'h7, sda_v: 1'b1, tick: 16'h0, ph: 2'h0, bcnt: 3'h7,
				byte_i: 3'h0, sh: 8'h00, rd: 1'b0, nack: 1'b0, done: 1'b0,
				scl_oe_n: 1'b1, sda_oe_n: 1'b1, addr: 16'h0000, wd: 8'h00,
				rdata: 8'h00, sel: 3'h0};
		end else if (ce) begin
			q <= d;
		end
	end

	assign link.scl_o = 1'b0;
	assign link.scl_oe_n = q.scl_oe_n;
	assign link.sda_ctl_o = 1'b0;
	assign link.sda_ctl_oe_n = q.sda_oe_n;
	assign done = q.done;
	assign nack = q.nack;
	assign rdata = q.rdata;
	// one-hot state: bit 0 is the idle state
	assign idle = q.st[0];
endmodule

// ===== verif/eeprom_link_checker.sv
// checker: framing and edge timing on the two-wire link between both ends
// assumes the interface's resolved lines and the system clock and reset
module eeprom_link_checker
	import eeprom_link_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe_n
);
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		logic in_frame;
		logic rd;
		logic [5:0] cnt;
	} watch_t;
	watch_t s_q, s_d;
	logic start, stop, rise;
	always_comb begin
		start = s_q.scl_q && scl && s_q.sda_q && !sda;
		stop = s_q.scl_q && scl && !s_q.sda_q && sda;
		rise = !s_q.scl_q && scl;
		s_d = s_q;
		s_d.scl_q = scl;
		s_d.sda_q = sda;
		if (start) begin
			s_d.in_frame = 1'b1;
			s_d.cnt = 6'h00;
			s_d.rd = 1'b0;
		end else if (stop) begin
			s_d.in_frame = 1'b0;
		end else if (rise && s_q.in_frame) begin
			s_d.cnt = s_q.cnt + 6'h01;
			// direction bit is the eighth bit of the frame
			if (s_q.cnt == 6'h07) begin
				s_d.rd = sda;
			end
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 6'h00};
		end else begin
			s_q <= s_d;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	dev_edge_a: assert property ($changed(sda_dev_oe_n) |-> !scl)
		else $error("device changed data while clock high");
	dev_idle_a: assert property (!s_q.in_frame |-> sda_dev_oe_n)
		else $error("device drives data outside a frame");
	ack_slot_a: assert property (rise && !sda_dev_oe_n && !s_q.rd |-> (s_q.cnt % 6'h09) == 6'h08)
		else $error("device drove outside an acknowledge slot");
	read_slot_a: assert property (rise && s_q.rd && !sda_dev_oe_n |-> s_q.cnt >= 6'h08 && s_q.cnt <= 6'h10)
		else $error("device drove past the read byte");
	frame_len_a: assert property (stop && s_q.in_frame |-> (s_q.cnt % 6'h09) == 6'h01)
		else $error("frame not whole nine-bit units");
	cond_edge_a: assert property (s_q.scl_q && scl && (sda != s_q.sda_q) |-> s_q.in_frame == sda)
		else $error("data changed under high clock out of place");
	scl_idle_a: assert property (!s_q.in_frame |-> scl)
		else $error("clock low outside a frame");
	scl_high_a: assert property ($rose(scl) |-> scl [*4])
		else $error("clock high phase too short");
	cover property (rise && !sda_dev_oe_n && !s_q.rd && s_q.cnt == 6'h23);
	cover property (rise && s_q.rd && s_q.cnt == 6'h11 && sda);
	cover property (stop && s_q.rd);
endmodule

// ===== verif/eeprom_i2c_slave_byte_write_bench.sv
// bench: both link ends joined; byte writes, reads, refusals, select-code change
// assumes the design package and interface; ends with one verdict line
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module eeprom_i2c_slave_byte_write_bench
	import eeprom_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROG = 600;
	typedef struct packed {
		logic nack;
		logic rd;
		logic [7:0] data;
	} note_t;
	note_t notes[$];
	note_t got;
	int bad_count = 0;
	int check_count = 0;
	logic clk = 1'b0, resetn = 1'b0, key_we = 1'b0, req = 1'b0, req_rd = 1'b0;
	logic [2:0] req_sel = 3'h0;
	logic [15:0] req_addr = 16'h0;
	logic [7:0] key_wdata = 8'h0, req_wdata = 8'h0, key_value, rdata;
	logic [2:0] select_code;
	logic busy, done, nack, idle;
	logic [39:0] bits = 40'h0;
	int nb = 0;
	eeprom_link_if lk();
	eeprom_dev #(.PROG_CYC(PROG), .LOAD_WAIT_CYC(50)) i_eeprom_dev (.clk(clk), .resetn(resetn),
		.ce(1'b1), .link(lk), .key_we(key_we), .key_wdata(key_wdata), .key_value(key_value),
		.busy(busy), .select_code(select_code));
	eeprom_ctl #(.HALF_CYC(8)) i_eeprom_ctl (.clk(clk), .resetn(resetn), .ce(1'b1), .link(lk),
		.req(req), .req_rd(req_rd), .req_sel(req_sel), .req_addr(req_addr),
		.req_wdata(req_wdata), .done(done), .nack(nack), .rdata(rdata), .idle(idle));
	eeprom_link_checker i_eeprom_link_checker (.clk(clk), .resetn(resetn), .scl(lk.scl),
		.sda(lk.sda), .sda_dev_oe_n(lk.sda_dev_oe_n));
	always #10 clk = ~clk;
	// wire capture: every clock rise shifts in data, a start clears the count
	always @(posedge lk.scl) begin
		bits = {bits[38:0], lk.sda};
		nb++;
	end
	always @(negedge lk.sda) if (lk.scl) nb = 0;
	always @(negedge clk) begin
		if (done === 1'b1 && notes.size() > 0) begin
			got = notes.pop_front();
			`CHK(nack, got.nack)
			`CHK(idle, 1'b1)
			if (got.rd) `CHK(rdata, got.data)
		end
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic xfer(input logic rd, input logic [2:0] sel, input logic [15:0] a,
		input logic [7:0] d, input logic en, input logic [7:0] ed);
		int i;
		notes.push_back('{en, rd, ed});
		@(posedge clk);
		#2;
		req = 1'b1;
		req_rd = rd;
		req_sel = sel;
		req_addr = a;
		req_wdata = d;
		@(posedge clk);
		#2;
		req = 1'b0;
		`CHK(idle, 1'b0)
		for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
		if (i == 4000) begin
			bad_count++;
			$display("[FAIL] %0t no done", $time);
		end
		`CHK(bits[nb-1 -: 8], {DEV_TYPE_CODE, sel, rd})
		if (!en && !rd) `CHK(bits[36:1], {DEV_TYPE_CODE, sel, 2'b00, a[15:8], 1'b0, a[7:0], 1'b0, d, 1'b0})
		if (rd) `CHK(bits[18:1], {DEV_TYPE_CODE, sel, 2'b10, ed, 1'b1})
	endtask
	task automatic wait_busy(output int n);
		for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk);
	endtask
	// stop must leave the device busy for the programming time
	task automatic prog(input bit timed);
		int n;
		repeat (10) @(negedge clk);
		`CHK(busy, 1'b1)
		wait_busy(n);
		if (timed) `CHK(n + 10 >= PROG - 10 && n + 10 <= PROG + 20, 1'b1)
	endtask
	initial begin
		int el;
		logic [8:0] a;
		logic [7:0] d0, d1;
		logic [2:0] ns;
		void'($urandom(94728));
		repeat (10) @(posedge clk);
		#2;
		resetn = 1'b1;
		`CHK(busy, 1'b1)
		`CHK(select_code, 3'h0)
		`CHK(key_value, KEY_RESET)
		wait_busy(el);
		`CHK(el > 44 && el < 56, 1'b1)
		`CHK(select_code, SELECT_CODE_INIT[2:0])
		xfer(0, 3'h5, 16'h0000, 8'h00, 1, 0);
		for (int r = 0; r < 3; r++) begin
			a = 9'($urandom_range(0, 255));
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			xfer(0, 3'h0, {7'h00, a + 9'h001}, d1, 0, 0);
			prog(1);
			xfer(0, 3'h0, {7'h00, a}, d0, 0, 0);
			if (r == 0) xfer(0, 3'h0, {7'h00, a}, 8'h00, 1, 0);
			prog(r != 0);
			xfer(1, 3'h0, 16'h0000, 8'h00, 0, d0);
			xfer(1, 3'h0, 16'h0000, 8'h00, 0, d1);
		end
		@(posedge clk);
		#2;
		key_we = 1'b1;
		key_wdata = KEY_UNLOCK;
		@(posedge clk);
		#2;
		key_we = 1'b0;
		`CHK(key_value, KEY_UNLOCK)
		ns = 3'($urandom_range(1, 7));
		xfer(0, 3'h0, SELECT_CODE_LOC, {5'h00, ns}, 0, 0);
		prog(1);
		`CHK(select_code, ns)
		`CHK(key_value, KEY_RESET)
		xfer(0, 3'h0, 16'h0020, d0, 1, 0);
		xfer(0, ns, 16'h0020, d0, 0, 0);
		prog(1);
		finish_test;
	end
	initial begin
		#1200000;
		bad_count++;
		finish_test;
	end
endmodule
